/* src/mhr_pkg.sv */
// Behaviour
// (R1) Function 03 reads holding registers, fixed fields.
// (R2) Read with address 0 is invalid.
// (R3) Read register number is address plus 40001.
// (R4) Read count limited to 125 registers.
// (R5) Read byte count twice count, 02 to FA.
// (R6) Read data high byte first, ascending order.
// (R7) Function 06 writes one register, fixed fields.
// (R8) Write register number is address plus 40001.
// (R9) Write to address 0 is performed broadcast.
// (R10) Write response echoes query byte for byte.
// (R11) No response to any broadcast query.
// (R12) Master waits processing time after broadcast.
// (R13) Diagnostics subfunction 00 echoes the query.
// (R14) Address byte: 0 broadcast, own station answers.
// (R15) CRC sent low byte first, then checked.
// (R16) Unsupported function code gives error response.
// (R17) Foreign station frames are silently discarded.
// (R18) Frames with bad CRC are silently discarded.
package mhr_pkg;
  localparam logic [7:0] MHR_FN_READ = 8'h03;
  localparam logic [7:0] MHR_FN_WRITE = 8'h06;
  localparam logic [7:0] MHR_FN_DIAG = 8'h08;
  localparam logic [7:0] MHR_SUB_ECHO = 8'h00;
  localparam logic [7:0] MHR_BCAST = 8'h00;
  localparam logic [7:0] MHR_STATION_MAX = 8'hF7;
  localparam logic [7:0] MHR_MAX_COUNT = 8'h7D;
  localparam logic [7:0] MHR_ERR_FLAG = 8'h80;
  localparam logic [7:0] MHR_EXC_FUNC = 8'h01;
  localparam logic [15:0] MHR_REG_BASE = 16'h9C41;
  localparam logic [15:0] MHR_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] MHR_CRC_POLY = 16'hA001;
  localparam int MHR_FRAME_LEN = 8;
  localparam logic [3:0] MHR_LAST_IDX = 4'h7;
  typedef enum logic [5:0]
  {
    MHR_IDLE = 6'b00_0001,
    MHR_RECV = 6'b00_0010,
    MHR_EXEC = 6'b00_0100,
    MHR_HEAD = 6'b00_1000,
    MHR_DATA = 6'b01_0000,
    MHR_TAIL = 6'b10_0000
  } mhr_state_e;
endpackage

/* src/mhr_crc.sv */
`timescale 1ns/1ps
module mhr_crc
  import mhr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic step,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // ----------------------------------------
  // Bytewise CRC update, reflected polynomial.
  // ----------------------------------------
  always_comb
  begin
    crc_d = (clear ? MHR_CRC_INIT : crc_q) ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ MHR_CRC_POLY) : (crc_d >> 1);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crc_q <= MHR_CRC_INIT;
    end
    else if (step)
    begin
      crc_q <= crc_d;
    end
    else if (clear)
    begin
      crc_q <= MHR_CRC_INIT;
    end
  end

  assign crc = crc_q;
endmodule

/* src/mhr_slave.sv */
`timescale 1ns/1ps
module mhr_slave
  import mhr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] station,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic rd_req,
  output logic [15:0] rd_reg,
  input wire logic [15:0] rd_data,
  output logic wr_req,
  output logic [15:0] wr_reg,
  output logic [15:0] wr_data
);
  import mhr_pkg::*;

  mhr_state_e state_q;
  logic [7:0] buf_q [0:MHR_FRAME_LEN-1];
  logic [3:0] rx_cnt_q;
  logic [3:0] tx_idx_q;
  logic [7:0] left_q;
  logic lowb_q;
  logic [15:0] word_q;
  logic [15:0] addr_q;
  logic echo_q;
  logic err_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_last_q;
  logic rd_req_q;
  logic [15:0] rd_reg_q;
  logic wr_req_q;
  logic [15:0] wr_reg_q;
  logic [15:0] wr_data_q;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic tx_fire;
  logic [7:0] fn;
  logic [15:0] f_addr;
  logic [15:0] f_word;
  logic addr_ok;
  logic bcast;
  logic good_len;
  logic [7:0] next_byte;
  logic tx_step;

  assign fn = buf_q[1];
  assign f_addr = {buf_q[2], buf_q[3]};
  assign f_word = {buf_q[4], buf_q[5]};
  assign bcast = buf_q[0] == MHR_BCAST; // [R14]
  assign addr_ok = bcast || (buf_q[0] == station && station <= MHR_STATION_MAX); // [R14] [R17]
  assign good_len = rx_cnt_q == 4'(MHR_FRAME_LEN);
  assign tx_fire = tx_valid_q && tx_ready;

  // ----------------------------------------
  // Checksums for reception and transmission.
  // ----------------------------------------
  mhr_crc u_rx_crc
  (
    .clk(clk),
    .nrst(nrst),
    .clear(state_q == MHR_IDLE),
    .step(rx_valid && (state_q == MHR_IDLE || state_q == MHR_RECV)),
    .data(rx_data),
    .crc(rx_crc)
  );

  assign tx_step = tx_fire && state_q != MHR_TAIL;

  mhr_crc u_tx_crc
  (
    .clk(clk),
    .nrst(nrst),
    .clear(state_q == MHR_EXEC),
    .step(tx_step),
    .data(tx_data_q),
    .crc(tx_crc)
  );

  // ----------------------------------------
  // Frame capture.
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_cnt_q <= 4'h0;
      for (int i = 0; i < MHR_FRAME_LEN; i++)
      begin
        buf_q[i] <= 8'h00;
      end
    end
    else if (rx_valid && (state_q == MHR_IDLE || state_q == MHR_RECV))
    begin
      if (state_q == MHR_IDLE)
      begin
        rx_cnt_q <= 4'h1;
        buf_q[0] <= rx_data;
      end
      else if (rx_cnt_q < 4'(MHR_FRAME_LEN))
      begin
        buf_q[rx_cnt_q[2:0]] <= rx_data;
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      else
      begin
        rx_cnt_q <= 4'hF;
      end
    end
  end

  // ----------------------------------------
  // Sequencer.
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= MHR_IDLE;
      echo_q <= 1'b0;
      err_q <= 1'b0;
      left_q <= 8'h00;
      addr_q <= 16'h0000;
      tx_idx_q <= 4'h0;
      lowb_q <= 1'b0;
      word_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        MHR_IDLE:
        begin
          if (rx_valid)
          begin
            state_q <= MHR_RECV;
          end
        end
        MHR_RECV:
        begin
          if (rx_end)
          begin
            state_q <= MHR_IDLE;
            // A good frame leaves a residue of zero once its CRC is included.
            if (good_len && rx_crc == 16'h0000 && addr_ok) // [R15] [R18] [R17]
            begin
              echo_q <= 1'b0;
              err_q <= 1'b0;
              tx_idx_q <= 4'h0;
              if (fn == MHR_FN_READ) // [R1]
              begin
                if (!bcast && f_word != 16'h0000 && f_word <= {8'h00, MHR_MAX_COUNT}) // [R2] [R4]
                begin
                  left_q <= f_word[7:0];
                  addr_q <= f_addr;
                  state_q <= MHR_EXEC;
                end
              end
              else if (fn == MHR_FN_WRITE) // [R7]
              begin
                echo_q <= 1'b1; // [R10]
                state_q <= bcast ? MHR_IDLE : MHR_EXEC; // [R9] [R11]
              end
              else if (fn == MHR_FN_DIAG && !bcast && f_addr == {MHR_SUB_ECHO, MHR_SUB_ECHO})
              begin
                echo_q <= 1'b1; // [R13]
                state_q <= MHR_EXEC;
              end
              else if (!bcast)
              begin
                err_q <= 1'b1; // [R16]
                state_q <= MHR_EXEC;
              end
            end
          end
        end
        MHR_EXEC:
        begin
          state_q <= MHR_HEAD;
        end
        MHR_HEAD:
        begin
          if (tx_fire)
          begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (echo_q && tx_idx_q == MHR_LAST_IDX)
            begin
              state_q <= MHR_IDLE;
            end
            else if (!echo_q && tx_idx_q == 4'h2)
            begin
              state_q <= err_q ? MHR_TAIL : MHR_DATA;
              lowb_q <= 1'b0;
              word_q <= rd_data;
              tx_idx_q <= 4'h0;
            end
          end
        end
        MHR_DATA:
        begin
          if (tx_fire)
          begin
            lowb_q <= !lowb_q; // [R6]
            if (lowb_q)
            begin
              left_q <= left_q - 8'h01;
              addr_q <= addr_q + 16'h0001; // [R6]
              word_q <= rd_data;
              if (left_q == 8'h01)
              begin
                state_q <= MHR_TAIL;
              end
            end
          end
        end
        MHR_TAIL:
        begin
          if (tx_fire)
          begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q == 4'h1)
            begin
              state_q <= MHR_IDLE;
            end
          end
        end
        default:
        begin
          state_q <= MHR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Next outgoing byte.
  // ----------------------------------------
  always_comb
  begin
    next_byte = 8'h00;
    case (state_q)
      MHR_EXEC:
      begin
        next_byte = buf_q[0];
      end
      MHR_HEAD:
      begin
        if (echo_q)
        begin
          next_byte = buf_q[tx_idx_q[2:0] + 3'h1]; // [R10] [R13]
        end
        else if (tx_idx_q == 4'h0)
        begin
          next_byte = err_q ? (fn | MHR_ERR_FLAG) : fn;
        end
        else if (tx_idx_q == 4'h1)
        begin
          next_byte = err_q ? MHR_EXC_FUNC : {left_q[6:0], 1'b0}; // [R5]
        end
        else
        begin
          next_byte = err_q ? tx_crc_next_lo() : rd_data[15:8]; // [R6]
        end
      end
      MHR_DATA:
      begin
        next_byte = lowb_q ? rd_data[15:8] : word_q[7:0]; // [R6]
      end
      MHR_TAIL:
      begin
        next_byte = tx_crc[15:8]; // [R15]
      end
      default:
      begin
        next_byte = 8'h00;
      end
    endcase
  end

  function automatic logic [7:0] tx_crc_next_lo();
    tx_crc_next_lo = 8'h00;
  endfunction

  // ----------------------------------------
  // Transmit stream register.
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
    end
    else if (state_q == MHR_EXEC)
    begin
      tx_valid_q <= 1'b1;
      tx_data_q <= next_byte;
      tx_last_q <= 1'b0;
    end
    else if (tx_fire)
    begin
      if (tx_last_q)
      begin
        tx_valid_q <= 1'b0;
        tx_last_q <= 1'b0;
      end
      else if (!echo_q && ((state_q == MHR_DATA && lowb_q && left_q == 8'h01) ||
               (state_q == MHR_HEAD && err_q && tx_idx_q == 4'h2)))
      begin
        tx_data_q <= tx_crc_after(tx_crc, tx_data_q); // [R15]
      end
      else if (state_q == MHR_TAIL)
      begin
        tx_data_q <= next_byte;
        tx_last_q <= 1'b1;
      end
      else
      begin
        tx_data_q <= next_byte;
        tx_last_q <= echo_q && tx_idx_q == MHR_LAST_IDX - 4'h1;
      end
    end
  end

  function automatic logic [7:0] tx_crc_after(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      v = v[0] ? ((v >> 1) ^ MHR_CRC_POLY) : (v >> 1);
    end
    tx_crc_after = v[7:0];
  endfunction

  // ----------------------------------------
  // Register access.
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_req_q <= 1'b0;
      rd_reg_q <= 16'h0000;
      wr_req_q <= 1'b0;
      wr_reg_q <= 16'h0000;
      wr_data_q <= 16'h0000;
    end
    else
    begin
      rd_req_q <= state_q == MHR_EXEC || state_q == MHR_DATA;
      // In the data phase the register bus looks one register ahead, so the next high byte is ready in time.
      rd_reg_q <= (state_q == MHR_DATA ? addr_q + 16'h0001 : addr_q) + MHR_REG_BASE; // [R3] [R6]
      wr_req_q <= rx_end && state_q == MHR_RECV && good_len && rx_crc == 16'h0000 && addr_ok &&
                  fn == MHR_FN_WRITE; // [R9]
      wr_reg_q <= f_addr + MHR_REG_BASE; // [R8]
      wr_data_q <= f_word;
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign rd_req = rd_req_q;
  assign rd_reg = rd_reg_q;
  assign wr_req = wr_req_q;
  assign wr_reg = wr_reg_q;
  assign wr_data = wr_data_q;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  AST_BCAST_SILENT: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    (state_q == MHR_RECV && rx_end && bcast) |=> state_q == MHR_IDLE)
    else $error("Broadcast started a response.");
  AST_BCAST_WRITE: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    (state_q == MHR_RECV && rx_end && good_len && rx_crc == 16'h0000 && bcast && fn == MHR_FN_WRITE) |=> wr_req)
    else $error("Broadcast write not performed.");
  AST_WR_OFFSET: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    wr_req |-> wr_reg == $past(f_addr) + MHR_REG_BASE)
    else $error("Write register offset wrong.");
  AST_BAD_CRC: assert property (@(posedge clk) disable iff (!nrst) // [R18]
    (state_q == MHR_RECV && rx_end && rx_crc != 16'h0000) |=> (state_q == MHR_IDLE && !wr_req))
    else $error("Bad frame accepted.");
  AST_FOREIGN: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    (state_q == MHR_RECV && rx_end && !addr_ok) |=> state_q == MHR_IDLE)
    else $error("Foreign frame accepted.");
  AST_COUNT: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (state_q == MHR_RECV && rx_end && fn == MHR_FN_READ && f_word > 16'h007D) |=> state_q == MHR_IDLE)
    else $error("Oversized read accepted.");
  AST_READ_BCAST: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    (state_q == MHR_RECV && rx_end && fn == MHR_FN_READ && bcast) |=> state_q == MHR_IDLE)
    else $error("Broadcast read accepted.");
  AST_START_ADDR: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    (state_q == MHR_EXEC) |=> tx_valid && tx_data == $past(buf_q[0]))
    else $error("Response does not start with address.");
endmodule

/* tb/mhr_master.sv */
`timescale 1ns/1ps
module mhr_master
  import mhr_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  // ----------------------------------------
  // Serial bus master
  // ----------------------------------------
  logic [7:0] rsp [$];

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end

  // Bytes go out in field order, CRC low byte before high byte.
  task automatic send(input logic [63:0] f);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= f[63 - 8 * i -: 8];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~f[7:0];
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask

  // The listening window also serves as the wait after a broadcast.
  task automatic collect(input int limit);
    rsp.delete();
    for (int i = 0; i < limit; i++)
    begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
        rsp.push_back(tx_data);
        if (tx_last === 1'b1)
          break;
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    tx_ready <= 1'b0;
  endtask
endmodule

/* tb/modbus_holding_register_slave_tb.sv */
`timescale 1ns/1ps
module modbus_holding_register_slave_tb;
  import mhr_pkg::*;
  // ----------------------------------------
  // Signals and helpers
  // ----------------------------------------
  logic clk, nrst, slow, rx_valid, rx_end, tx_ready, tx_valid, tx_last, rd_req, wr_req;
  logic [7:0] station, rx_data, tx_data;
  logic [15:0] rd_reg, rd_data, wr_reg, wr_data, wr_reg_seen, wr_data_seen;
  int bad_count, checked, wr_cnt, rd_cnt, w0, r0;
  logic [7:0] exp_q [$];

  function automatic logic [15:0] regval(input logic [15:0] r);
    case (r)
      16'hA02C: return 16'h1770;
      16'hA02D: return 16'h0BB8;
      16'hA02E: return 16'h03E8;
      default: return ~r;
    endcase
  endfunction

  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = MHR_CRC_INIT;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ MHR_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  assign rd_data = regval(rd_reg);

  always @(posedge clk)
  begin
    if (wr_req === 1'b1)
    begin
      wr_cnt++;
      wr_reg_seen = wr_reg;
      wr_data_seen = wr_data;
    end
    if (rd_req === 1'b1)
      rd_cnt++;
  end

  mhr_slave i_dut (.clk(clk), .nrst(nrst), .station(station), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .rd_req(rd_req), .rd_reg(rd_reg), .rd_data(rd_data), .wr_req(wr_req), .wr_reg(wr_reg), .wr_data(wr_data));

  mhr_master i_master (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xact(input logic [7:0] a, f, h1, l1, h2, l2, input bit bad, input int lim);
    logic [7:0] q [$];
    logic [15:0] c;
    q = {a, f, h1, l1, h2, l2};
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8] ^ {7'h00, bad});
    exp_q = q;
    w0 = wr_cnt;
    r0 = rd_cnt;
    i_master.send({q[0], q[1], q[2], q[3], q[4], q[5], q[6], q[7]});
    i_master.collect(lim);
  endtask

  task automatic add_crc();
    logic [15:0] c;
    c = crc16(exp_q);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask

  task automatic cmp_rsp();
    check(16'(i_master.rsp.size()), 16'(exp_q.size()));
    if (i_master.rsp.size() != exp_q.size())
      report_and_stop();
    if (i_master.rsp.size() == exp_q.size())
      foreach (exp_q[i])
        check({8'h00, i_master.rsp[i]}, {8'h00, exp_q[i]});
  endtask

  task automatic check_silent();
    check(16'(i_master.rsp.size()), 16'h0000);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_read_example();
    xact(8'h11, 8'h03, 8'h03, 8'hEB, 8'h00, 8'h03, 1'b0, 60);
    exp_q = {8'h11, 8'h03, 8'h06, 8'h17, 8'h70, 8'h0B, 8'hB8, 8'h03, 8'hE8, 8'h2C, 8'hE6};
    cmp_rsp();
  endtask

  task automatic t_read_max();
    logic [15:0] r;
    slow = 1'b1;
    xact(8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h7D, 1'b0, 1200);
    exp_q = {8'h11, 8'h03, 8'hFA};
    for (int i = 0; i < 125; i++)
    begin
      r = 16'h0010 + MHR_REG_BASE + 16'(i);
      exp_q.push_back(~r[15:8]);
      exp_q.push_back(~r[7:0]);
    end
    add_crc();
    cmp_rsp();
    slow = 1'b0;
  endtask

  task automatic t_read_refused();
    xact(8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00, 1'b0, 40);
    check_silent();
    xact(8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h7E, 1'b0, 40);
    check_silent();
    xact(8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01, 1'b0, 40);
    check_silent();
    check(16'(rd_cnt - r0), 16'h0000);
  endtask

  task automatic t_write();
    @(posedge clk);
    station <= 8'h05;
    xact(8'h05, 8'h06, 8'h00, 8'h0D, 8'h17, 8'h70, 1'b0, 60);
    check({exp_q[6], exp_q[7]}, 16'h1799);
    check(16'(wr_cnt - w0), 16'h0001);
    check(wr_reg_seen, 16'h9C4E);
    check(wr_data_seen, 16'h1770);
    cmp_rsp();
  endtask

  task automatic t_bcast_write();
    slow = 1'b1;
    xact(8'h00, 8'h06, 8'h00, 8'h20, 8'hAB, 8'hCD, 1'b0, 40);
    check_silent();
    check(16'(wr_cnt - w0), 16'h0001);
    check(wr_reg_seen, 16'h9C61);
    check(wr_data_seen, 16'hABCD);
    slow = 1'b0;
  endtask

  task automatic t_diag();
    xact(8'h05, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34, 1'b0, 60);
    cmp_rsp();
  endtask

  task automatic t_discard();
    xact(8'h06, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01, 1'b0, 40);
    check_silent();
    xact(8'h05, 8'h06, 8'h00, 8'h20, 8'h11, 8'h22, 1'b1, 40);
    check_silent();
    check(16'(wr_cnt - w0), 16'h0000);
  endtask

  task automatic t_bad_func();
    xact(8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 60);
    exp_q = {8'h05, 8'h84, 8'h01};
    add_crc();
    cmp_rsp();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    nrst = 1'b0;
    station = 8'h11;
    slow = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_read_example();
    t_read_max();
    t_read_refused();
    t_write();
    t_bcast_write();
    t_diag();
    t_discard();
    t_bad_func();
    report_and_stop();
  end
endmodule
